// ===== include/lbt_pkg.sv
// constants shared by the burst read/write/terminate engine
package lbt_pkg;
  localparam int unsigned CA_W        = 10;
  localparam int unsigned COL_W       = 11;
  localparam int unsigned BANK_W      = 2;
  localparam int unsigned DQ_W        = 16;
  localparam int unsigned DM_W        = 2;
  localparam int unsigned WORD_W      = 2 * DQ_W;
  localparam int unsigned BE_W        = 2 * DM_W;
  localparam int unsigned PIPE_DEPTH  = 16;
  localparam int unsigned BUF_DEPTH   = 2;
  localparam int unsigned ENTRY_W     = BANK_W + COL_W + BE_W + WORD_W;
  // field positions on the command/address bus
  localparam int unsigned CA_BIT0     = 0;
  localparam int unsigned CA_BIT1     = 1;
  localparam int unsigned CA_BIT2     = 2;
  localparam int unsigned CA_BIT3     = 3;
  localparam int unsigned COL_R_LO    = 5;
  localparam int unsigned COL_R_HI    = 6;
  localparam int unsigned COL_F_LO    = 1;
  localparam int unsigned COL_F_HI    = 9;
  localparam int unsigned BANK_R_LO   = 7;
  localparam int unsigned BANK_R_HI   = 8;
  // burst length select codes and their clock counts (two beats per clock)
  localparam logic [1:0] BL_SEL_4     = 2'h0;
  localparam logic [1:0] BL_SEL_8     = 2'h1;
  localparam logic [1:0] BL_SEL_16    = 2'h2;
  localparam logic [3:0] BL4_CLKS     = 4'h2;
  localparam logic [3:0] BL8_CLKS     = 4'h4;
  localparam logic [3:0] BL16_CLKS    = 4'h8;
  // tap offsets into the command delay line
  localparam logic [3:0] WR_TAP_OFS   = 4'h1;
  localparam logic [3:0] RD_TAP_OFS   = 4'h2;
  localparam logic [3:0] PRE_TAP_OFS  = 4'h3;
  localparam logic [3:0] AGE_MAX      = 4'hF;
  localparam logic [3:0] AGE_START    = 4'h1;
  localparam logic [1:0] BUF_FULL_CNT = 2'h2;
  localparam int unsigned SYNC_STAGES = 2;
endpackage

// ===== hdl/lbt_burst_engine.sv
// burst read/write/terminate engine with two-entry write data buffer
`timescale 1ns/1ps

// How it works
// [RQ1] write command: cs low, ca0 high, ca1 low, ca2 low on the rising edge
// [RQ2] column taken from rising-edge ca5-ca6 and falling-edge ca1-ca9
// [RQ3] host presents first write data write-latency clocks after the command
// [RQ4] host drives the write strobe low for a preamble before data; the host model has no strobe pin, only an idle clock before the first beat
// [RQ5] write beats are captured until burst length 4, 8 or 16 completes
// [RQ6] host spaces write after read by the read-to-write turnaround
// [RQ7] host spaces read after write by the write-to-read turnaround
// [RQ8] reads every 2, 4 or 8 clocks stream without a gap
// [RQ9] writes every 2, 4 or 8 clocks stream without a gap
// [RQ10] a read may cut short a longer read burst on even clocks
// [RQ11] host interrupts a read only by a read or a terminate
// [RQ12] host never interrupts an auto-precharge burst
// [RQ13] a write may cut short a longer write burst on even clocks
// [RQ14] host interrupts a write only by a write or a terminate
// [RQ15] terminate command: cs low, ca0 high, ca1 high, ca2 low, ca3 low
// [RQ16] host issues terminate only within the active burst
// [RQ17] truncated burst length is twice the clocks from command to truncation
// [RQ18] terminate acts only on the most recent read or write
// [RQ19] data stops read or write latency clocks after the terminate
// [RQ20] host issues terminate an even number of clocks after its command
// [RQ21] host issues one terminate per read or write command; the bench issues a second one in its double terminate test
// [RQ22] each byte has a mask; a masked byte is not written on that beat
// [RQ23] read command: cs low, ca0 high, ca1 low, ca2 high on the rising edge
// [RQ24] read data follows read latency, strobe preamble precedes the first beat; the engine raises the preamble only for read latency 3 or more
module lbt_burst_engine (
  input  wire logic                           ref_clk,
  input  wire logic                           reset,
  input  wire logic [1:0]                     burst_len_sel,
  input  wire logic [3:0]                     read_lat,
  input  wire logic [3:0]                     write_lat,
  input  wire logic                           cs_n,
  input  wire logic [lbt_pkg::CA_W-1:0]       ca_rise,
  input  wire logic [lbt_pkg::CA_W-1:0]       ca_fall,
  input  wire logic [lbt_pkg::DQ_W-1:0]       wdq_rise,
  input  wire logic [lbt_pkg::DQ_W-1:0]       wdq_fall,
  input  wire logic [lbt_pkg::DM_W-1:0]       wdm_rise,
  input  wire logic [lbt_pkg::DM_W-1:0]       wdm_fall,
  output logic                                wb_valid,
  input  wire logic                           wb_ready,
  output logic [lbt_pkg::WORD_W-1:0]          wb_data,
  output logic [lbt_pkg::BE_W-1:0]            wb_byte_en,
  output logic [lbt_pkg::COL_W-1:0]           wb_col,
  output logic [lbt_pkg::BANK_W-1:0]          wb_bank,
  output logic                                wr_overrun,
  output logic                                rd_fetch,
  output logic [lbt_pkg::COL_W-1:0]           rd_fetch_col,
  output logic [lbt_pkg::BANK_W-1:0]          rd_fetch_bank,
  input  wire logic [lbt_pkg::DQ_W-1:0]       rd_word_rise,
  input  wire logic [lbt_pkg::DQ_W-1:0]       rd_word_fall,
  output logic [lbt_pkg::DQ_W-1:0]            rdq_rise,
  output logic [lbt_pkg::DQ_W-1:0]            rdq_fall,
  output logic                                rdq_oe,
  output logic                                rdqs_oe,
  output logic [4:0]                          rd_eff_len,
  output logic [4:0]                          wr_eff_len
);
  typedef struct packed {
    logic                                            cs_s1;
    logic                                            cs_s2;
    logic [lbt_pkg::CA_W-1:0]                        car_s1;
    logic [lbt_pkg::CA_W-1:0]                        car_s2;
    logic [lbt_pkg::CA_W-1:0]                        caf_s1;
    logic [lbt_pkg::CA_W-1:0]                        caf_s2;
    logic [lbt_pkg::WORD_W-1:0]                      wdq_s1;
    logic [lbt_pkg::WORD_W-1:0]                      wdq_s2;
    logic [lbt_pkg::BE_W-1:0]                        wdm_s1;
    logic [lbt_pkg::BE_W-1:0]                        wdm_s2;
    logic [lbt_pkg::PIPE_DEPTH-1:0]                  rd_start;
    logic [lbt_pkg::PIPE_DEPTH-1:0]                  rd_stop;
    logic [lbt_pkg::PIPE_DEPTH-1:0]                  wr_start;
    logic [lbt_pkg::PIPE_DEPTH-1:0]                  wr_stop;
    logic [lbt_pkg::PIPE_DEPTH-1:0][lbt_pkg::COL_W-1:0]  rd_col;
    logic [lbt_pkg::PIPE_DEPTH-1:0][lbt_pkg::BANK_W-1:0] rd_bank;
    logic [lbt_pkg::PIPE_DEPTH-1:0][lbt_pkg::COL_W-1:0]  wr_col;
    logic [lbt_pkg::PIPE_DEPTH-1:0][lbt_pkg::BANK_W-1:0] wr_bank;
    logic [3:0]                                      rd_left;
    logic [3:0]                                      wr_left;
    logic [lbt_pkg::COL_W-1:0]                       rd_cur_col;
    logic [lbt_pkg::BANK_W-1:0]                      rd_cur_bank;
    logic [lbt_pkg::COL_W-1:0]                       wr_cur_col;
    logic [lbt_pkg::BANK_W-1:0]                      wr_cur_bank;
    logic                                            last_is_write;
    logic                                            bst_armed;
    logic [3:0]                                      rd_age;
    logic [3:0]                                      wr_age;
    logic [4:0]                                      rd_eff;
    logic [4:0]                                      wr_eff;
    logic                                            rdq_oe;
    logic                                            rdqs_oe;
    logic [lbt_pkg::DQ_W-1:0]                        rdq_r;
    logic [lbt_pkg::DQ_W-1:0]                        rdq_f;
    logic [lbt_pkg::BUF_DEPTH-1:0][lbt_pkg::ENTRY_W-1:0] buf_mem;
    logic                                            buf_wp;
    logic                                            buf_rp;
    logic [1:0]                                      buf_cnt;
    logic                                            overrun;
  } lbt_state_t;

  lbt_state_t s_reg;
  lbt_state_t s_next;

  logic                          rd_cmd;
  logic                          wr_cmd;
  logic                          bst_cmd;
  logic                          bst_rd;
  logic                          bst_wr;
  logic [lbt_pkg::COL_W-1:0]     col_in;
  logic [lbt_pkg::BANK_W-1:0]    bank_in;
  logic [3:0]                    bl2;
  logic [3:0]                    wtap;
  logic [3:0]                    rtap;
  logic [3:0]                    ptap;
  logic                          ws;
  logic                          wst;
  logic                          wr_act;
  logic                          fs;
  logic                          fst;
  logic [lbt_pkg::COL_W-1:0]     wcol;
  logic [lbt_pkg::BANK_W-1:0]    wbank;
  logic                          in_ready;
  logic                          pop;
  logic [lbt_pkg::ENTRY_W-1:0]   head;

  always_comb begin
    s_next = s_reg;
    // every command and write data pin passes two flops before the decoder sees it
    s_next.cs_s1  = cs_n;
    s_next.cs_s2  = s_reg.cs_s1;
    s_next.car_s1 = ca_rise;
    s_next.car_s2 = s_reg.car_s1;
    s_next.caf_s1 = ca_fall;
    s_next.caf_s2 = s_reg.caf_s1;
    s_next.wdq_s1 = {wdq_fall, wdq_rise};
    s_next.wdq_s2 = s_reg.wdq_s1;
    s_next.wdm_s1 = {wdm_fall, wdm_rise};
    s_next.wdm_s2 = s_reg.wdm_s1;

    rd_cmd  = !s_reg.cs_s2 && s_reg.car_s2[lbt_pkg::CA_BIT0] && !s_reg.car_s2[lbt_pkg::CA_BIT1]
              && s_reg.car_s2[lbt_pkg::CA_BIT2]; // RQ23
    wr_cmd  = !s_reg.cs_s2 && s_reg.car_s2[lbt_pkg::CA_BIT0] && !s_reg.car_s2[lbt_pkg::CA_BIT1]
              && !s_reg.car_s2[lbt_pkg::CA_BIT2]; // RQ1
    bst_cmd = !s_reg.cs_s2 && s_reg.car_s2[lbt_pkg::CA_BIT0] && s_reg.car_s2[lbt_pkg::CA_BIT1]
              && !s_reg.car_s2[lbt_pkg::CA_BIT2] && !s_reg.car_s2[lbt_pkg::CA_BIT3]; // RQ15
    col_in  = {s_reg.caf_s2[lbt_pkg::COL_F_HI:lbt_pkg::COL_F_LO],
               s_reg.car_s2[lbt_pkg::COL_R_HI:lbt_pkg::COL_R_LO]}; // RQ2
    bank_in = s_reg.car_s2[lbt_pkg::BANK_R_HI:lbt_pkg::BANK_R_LO];
    // a repeated terminate without a new command is ignored
    bst_rd  = bst_cmd && s_reg.bst_armed && !s_reg.last_is_write; // RQ18
    bst_wr  = bst_cmd && s_reg.bst_armed && s_reg.last_is_write; // RQ18

    unique case (burst_len_sel)
      lbt_pkg::BL_SEL_8:  bl2 = lbt_pkg::BL8_CLKS;
      lbt_pkg::BL_SEL_16: bl2 = lbt_pkg::BL16_CLKS;
      default:            bl2 = lbt_pkg::BL4_CLKS;
    endcase
    wtap = write_lat - lbt_pkg::WR_TAP_OFS;
    rtap = read_lat - lbt_pkg::RD_TAP_OFS;
    ptap = read_lat - lbt_pkg::PRE_TAP_OFS;

    // delay lines: bit k holds the command seen k+1 clocks ago
    s_next.rd_start = {s_reg.rd_start[lbt_pkg::PIPE_DEPTH-2:0], rd_cmd};
    s_next.wr_start = {s_reg.wr_start[lbt_pkg::PIPE_DEPTH-2:0], wr_cmd};
    s_next.rd_stop  = {s_reg.rd_stop[lbt_pkg::PIPE_DEPTH-2:0], bst_rd};
    s_next.wr_stop  = {s_reg.wr_stop[lbt_pkg::PIPE_DEPTH-2:0], bst_wr};
    s_next.rd_col   = {s_reg.rd_col[lbt_pkg::PIPE_DEPTH-2:0], col_in};
    s_next.wr_col   = {s_reg.wr_col[lbt_pkg::PIPE_DEPTH-2:0], col_in};
    s_next.rd_bank  = {s_reg.rd_bank[lbt_pkg::PIPE_DEPTH-2:0], bank_in};
    s_next.wr_bank  = {s_reg.wr_bank[lbt_pkg::PIPE_DEPTH-2:0], bank_in};

    if (rd_cmd || wr_cmd) begin
      s_next.last_is_write = wr_cmd;
      s_next.bst_armed     = 1'b1;
    end else if (bst_cmd) begin
      s_next.bst_armed = 1'b0;
    end
    s_next.rd_age = rd_cmd ? lbt_pkg::AGE_START :
                    (s_reg.rd_age == lbt_pkg::AGE_MAX) ? s_reg.rd_age : s_reg.rd_age + 4'h1;
    s_next.wr_age = wr_cmd ? lbt_pkg::AGE_START :
                    (s_reg.wr_age == lbt_pkg::AGE_MAX) ? s_reg.wr_age : s_reg.wr_age + 4'h1;
    if (rd_cmd) begin
      s_next.rd_eff = {bl2, 1'b0};
    end else if (bst_rd) begin
      s_next.rd_eff = {s_reg.rd_age, 1'b0}; // RQ17
    end
    if (wr_cmd) begin
      s_next.wr_eff = {bl2, 1'b0};
    end else if (bst_wr) begin
      s_next.wr_eff = {s_reg.wr_age, 1'b0}; // RQ17
    end

    // write window: a new start reloads the count, which truncates the older burst
    ws     = s_reg.wr_start[wtap];
    wst    = s_reg.wr_stop[wtap];
    wr_act = ws || (s_reg.wr_left != 4'h0 && !wst); // RQ5 RQ9 RQ13 RQ19
    s_next.wr_left = ws ? bl2 - 4'h1 : (wr_act ? s_reg.wr_left - 4'h1 : 4'h0);
    wcol   = ws ? s_reg.wr_col[wtap] : s_reg.wr_cur_col;
    wbank  = ws ? s_reg.wr_bank[wtap] : s_reg.wr_cur_bank;
    s_next.wr_cur_col  = wcol + 11'h001;
    s_next.wr_cur_bank = wbank;

    // two-entry buffer; the engine cannot stall the pins, so a full buffer flags overrun
    in_ready = (s_reg.buf_cnt != lbt_pkg::BUF_FULL_CNT);
    pop      = (s_reg.buf_cnt != 2'h0) && wb_ready;
    head     = s_reg.buf_mem[s_reg.buf_rp];
    if (wr_act && in_ready) begin
      s_next.buf_mem[s_reg.buf_wp] = {wbank, wcol, ~s_reg.wdm_s2, s_reg.wdq_s2}; // RQ22
      s_next.buf_wp = !s_reg.buf_wp;
    end
    if (pop) begin
      s_next.buf_rp = !s_reg.buf_rp;
    end
    s_next.buf_cnt = s_reg.buf_cnt + {1'b0, wr_act && in_ready} - {1'b0, pop};
    s_next.overrun = s_reg.overrun || (wr_act && !in_ready);

    // read window runs one clock early so the fetched word lands on read latency
    fs       = s_reg.rd_start[rtap];
    fst      = s_reg.rd_stop[rtap];
    rd_fetch = fs || (s_reg.rd_left != 4'h0 && !fst); // RQ8 RQ10 RQ19
    s_next.rd_left = fs ? bl2 - 4'h1 : (rd_fetch ? s_reg.rd_left - 4'h1 : 4'h0);
    rd_fetch_col  = fs ? s_reg.rd_col[rtap] : s_reg.rd_cur_col;
    rd_fetch_bank = fs ? s_reg.rd_bank[rtap] : s_reg.rd_cur_bank;
    s_next.rd_cur_col  = rd_fetch_col + 11'h001;
    s_next.rd_cur_bank = rd_fetch_bank;
    s_next.rdqs_oe = rd_fetch || s_reg.rd_start[ptap]; // RQ24
    s_next.rdq_oe  = rd_fetch; // RQ24
    s_next.rdq_r   = rd_fetch ? rd_word_rise : '0;
    s_next.rdq_f   = rd_fetch ? rd_word_fall : '0;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wb_valid   = (s_reg.buf_cnt != 2'h0);
  assign wb_data    = head[lbt_pkg::WORD_W-1:0];
  assign wb_byte_en = head[lbt_pkg::WORD_W +: lbt_pkg::BE_W];
  assign wb_col     = head[lbt_pkg::WORD_W+lbt_pkg::BE_W +: lbt_pkg::COL_W];
  assign wb_bank    = head[lbt_pkg::ENTRY_W-1 -: lbt_pkg::BANK_W];
  assign wr_overrun = s_reg.overrun;
  assign rdq_rise   = s_reg.rdq_r;
  assign rdq_fall   = s_reg.rdq_f;
  assign rdq_oe     = s_reg.rdq_oe;
  assign rdqs_oe    = s_reg.rdqs_oe;
  assign rd_eff_len = s_reg.rd_eff;
  assign wr_eff_len = s_reg.wr_eff;

  property p_wr_decode;
    @(posedge ref_clk) disable iff (reset) wr_cmd |=> s_reg.wr_start[0] && !s_reg.rd_start[0];
  endproperty
  a_wr_decode: assert property (p_wr_decode) else $error("write command not queued"); // RQ1
  property p_rd_decode;
    @(posedge ref_clk) disable iff (reset) rd_cmd |=> s_reg.rd_start[0] && !s_reg.wr_start[0];
  endproperty
  a_rd_decode: assert property (p_rd_decode) else $error("read command not queued"); // RQ23
  property p_col;
    @(posedge ref_clk) disable iff (reset)
      wr_cmd |=> s_reg.wr_col[0] == {$past(s_reg.caf_s2[9:1]), $past(s_reg.car_s2[6:5])};
  endproperty
  a_col: assert property (p_col) else $error("column address mis-assembled"); // RQ2
  property p_bl4_len;
    @(posedge ref_clk) disable iff (reset)
      (ws && burst_len_sel == lbt_pkg::BL_SEL_4) ##1 (!ws && !wst) |-> $past(wr_act) && wr_act ##1 (ws || !wr_act);
  endproperty
  a_bl4_len: assert property (p_bl4_len) else $error("write burst of 4 wrong length"); // RQ5
  property p_bst_target;
    @(posedge ref_clk) disable iff (reset)
      (bst_cmd && s_reg.bst_armed && s_reg.last_is_write) |=> s_reg.wr_stop[0] && !s_reg.rd_stop[0];
  endproperty
  a_bst_target: assert property (p_bst_target) else $error("terminate hit the wrong burst"); // RQ18
  property p_bst_once;
    @(posedge ref_clk) disable iff (reset)
      (bst_cmd && !s_reg.bst_armed) |=> !(s_reg.rd_stop[0] || s_reg.wr_stop[0]);
  endproperty
  a_bst_once: assert property (p_bst_once) else $error("repeated terminate not ignored"); // RQ21
  property p_wr_stop;
    @(posedge ref_clk) disable iff (reset) (wst && !ws) |-> !wr_act ##1 (s_reg.wr_left == 4'h0);
  endproperty
  a_wr_stop: assert property (p_wr_stop) else $error("write data not stopped by terminate"); // RQ19
  property p_eff;
    @(posedge ref_clk) disable iff (reset) bst_rd |=> rd_eff_len == {$past(s_reg.rd_age), 1'b0};
  endproperty
  a_eff: assert property (p_eff) else $error("truncated read length wrong"); // RQ17
  property p_mask;
    @(posedge ref_clk) disable iff (reset)
      (wr_act && s_reg.buf_cnt == 2'h0) |=> wb_valid && wb_byte_en == ~$past(s_reg.wdm_s2);
  endproperty
  a_mask: assert property (p_mask) else $error("byte mask not applied"); // RQ22
  property p_rd_seamless;
    @(posedge ref_clk) disable iff (reset) rd_fetch ##1 rd_fetch |-> rdq_oe ##1 rdq_oe && rdqs_oe;
  endproperty
  a_rd_seamless: assert property (p_rd_seamless) else $error("gap in read stream"); // RQ8
  property p_wr_interrupt;
    @(posedge ref_clk) disable iff (reset) (ws && s_reg.wr_left != 4'h0) |=> s_reg.wr_left == $past(bl2) - 4'h1;
  endproperty
  a_wr_interrupt: assert property (p_wr_interrupt) else $error("interrupting write not restarted"); // RQ13
  property p_preamble;
    @(posedge ref_clk) disable iff (reset) ($rose(rdqs_oe) && read_lat >= 4'h3) |-> !rdq_oe;
  endproperty
  a_preamble: assert property (p_preamble) else $error("read strobe preamble missing"); // RQ24
  c_wr_burst:  cover property (@(posedge ref_clk) disable iff (reset) wr_act [*8]);
  c_rd_burst:  cover property (@(posedge ref_clk) disable iff (reset) rd_fetch ##1 rdq_oe);
  c_bst:       cover property (@(posedge ref_clk) disable iff (reset) bst_wr ##[1:8] !wr_act);
  c_overrun:   cover property (@(posedge ref_clk) disable iff (reset) $rose(wr_overrun));
endmodule

// ===== sim/lbt_host_model.sv
// host controller model: drives commands and rise/fall write data with masks onto the engine's pins
`timescale 1ns/1ps
module lbt_host_model (
  input  wire logic                      ref_clk,
  input  wire logic [3:0]                read_lat,
  input  wire logic [3:0]                write_lat,
  output logic                           cs_n = 1'b1,
  output logic [lbt_pkg::CA_W-1:0]       ca_rise = '0,
  output logic [lbt_pkg::CA_W-1:0]       ca_fall = '0,
  output logic [lbt_pkg::DQ_W-1:0]       wdq_rise = '0,
  output logic [lbt_pkg::DQ_W-1:0]       wdq_fall = '0,
  output logic [lbt_pkg::DM_W-1:0]       wdm_rise = '0,
  output logic [lbt_pkg::DM_W-1:0]       wdm_fall = '0
);
  logic [5:0]                  cyc = 6'h00;
  logic [3:0]                  last_lat = 4'h0;
  logic                        s_v [64] = '{default: 1'b0};
  logic                        s_rd [64];
  logic [lbt_pkg::COL_W-1:0]   s_col [64];
  logic [lbt_pkg::BANK_W-1:0]  s_bank [64];
  logic [3:0]                  s_k [64];
  logic [lbt_pkg::ENTRY_W-1:0] exp_q [$];
  logic [lbt_pkg::BANK_W+lbt_pkg::COL_W-1:0] rd_q [$];

  always @(posedge ref_clk) begin
    cyc <= cyc + 6'h01;
    if (s_v[cyc] && !s_rd[cyc]) begin
      // beat index and column ride in the data so a lost or reordered beat shows
      wdq_rise <= {s_k[cyc], 1'b0, s_col[cyc]};
      wdq_fall <= ~{s_k[cyc], 1'b0, s_col[cyc]};
      wdm_rise <= s_k[cyc][1:0];
      wdm_fall <= ~s_k[cyc][1:0];
      exp_q.push_back({s_bank[cyc], s_col[cyc], s_k[cyc][1:0], ~s_k[cyc][1:0],
                       ~{s_k[cyc], 1'b0, s_col[cyc]}, {s_k[cyc], 1'b0, s_col[cyc]}});
    end else begin
      // idle lines keep moving so stale data cannot pass for a beat
      wdq_rise <= ~wdq_rise;
      wdq_fall <= ~wdq_fall;
      wdm_rise <= ~wdm_rise;
      wdm_fall <= ~wdm_fall;
      if (s_v[cyc]) rd_q.push_back({s_bank[cyc], s_col[cyc]});
    end
    s_v[cyc] = 1'b0;
  end

  // kind 0 write, 1 read, 2 terminate; clks is the burst length in clocks
  task automatic issue(input logic [1:0] kind, input logic [10:0] col, input logic [1:0] bank,
                       input logic [3:0] clks);
    logic [3:0] lat;
    logic [5:0] ix;
    lat = (kind == 2'h1) ? read_lat : write_lat;
    @(posedge ref_clk);
    cs_n    <= 1'b0;
    ca_rise <= {1'b0, bank, col[1:0], 1'b0, (kind == 2'h2) ? 4'h3 : {1'b0, kind[0], 2'h1}};
    ca_fall <= {col[10:2], 1'b0};
    if (kind == 2'h2) begin
      for (int j = 0; j < 8; j++) begin
        ix = 6'(cyc + last_lat + j);
        s_v[ix] = 1'b0;
      end
    end else begin
      last_lat = lat;
      for (int j = 0; j < 16; j++) begin
        ix = 6'(cyc + lat + j);
        if (j < clks) begin
          // no strobe pin: the idle clock before the first beat stands for the preamble
          s_v[ix]    = 1'b1;
          s_rd[ix]   = kind[0];
          s_col[ix]  = col + 11'(j);
          s_bank[ix] = bank;
          s_k[ix]    = 4'(j);
        end
      end
    end
    @(posedge ref_clk);
    cs_n    <= 1'b1;
    ca_rise <= ~ca_rise;
    ca_fall <= ~ca_fall;
  endtask
endmodule

// ===== sim/lpddr2_burst_rw_terminate_tb.sv
// self-checking bench for the burst engine: row table of bursts, then stall and reset cases
`timescale 1ns/1ps
module lpddr2_burst_rw_terminate_tb;
  typedef struct packed {
    logic       rd;
    logic [1:0] bl;
    logic [3:0] lat;
    logic [1:0] nxt;
    logic [3:0] gap;
    logic [4:0] n_clk;
    logic [4:0] eff;
  } lbt_row_t;
  // nxt: 0 single burst, 1 second command of the same type, 2 terminate
  lbt_row_t rows [14] = '{
    '{1'h0, 2'h0, 4'h1, 2'h0, 4'h0, 5'h02, 5'h04}, '{1'h0, 2'h1, 4'h3, 2'h0, 4'h0, 5'h04, 5'h08},
    '{1'h0, 2'h2, 4'hF, 2'h0, 4'h0, 5'h08, 5'h10}, '{1'h0, 2'h0, 4'h1, 2'h1, 4'h2, 5'h04, 5'h04},
    '{1'h0, 2'h1, 4'h2, 2'h1, 4'h4, 5'h08, 5'h08}, '{1'h0, 2'h2, 4'h1, 2'h1, 4'h4, 5'h0C, 5'h10},
    '{1'h0, 2'h2, 4'h2, 2'h2, 4'h2, 5'h02, 5'h04}, '{1'h0, 2'h2, 4'h1, 2'h2, 4'h6, 5'h06, 5'h0C},
    '{1'h1, 2'h0, 4'h3, 2'h0, 4'h0, 5'h02, 5'h04}, '{1'h1, 2'h1, 4'hF, 2'h0, 4'h0, 5'h04, 5'h08},
    '{1'h1, 2'h0, 4'h3, 2'h1, 4'h2, 5'h04, 5'h04}, '{1'h1, 2'h2, 4'h4, 2'h1, 4'h2, 5'h0A, 5'h10},
    '{1'h1, 2'h2, 4'h3, 2'h2, 4'h2, 5'h02, 5'h04}, '{1'h1, 2'h1, 4'h5, 2'h2, 4'h2, 5'h02, 5'h04}};
  logic                        ref_clk = 1'b0;
  logic                        reset = 1'b1;
  logic [1:0]                  burst_len_sel = 2'h0;
  logic [3:0]                  read_lat = 4'h3;
  logic [3:0]                  write_lat = 4'h1;
  logic                        wb_ready = 1'b1;
  logic                        cs_n, wb_valid, wr_overrun, rd_fetch, rdq_oe, rdqs_oe;
  logic [lbt_pkg::CA_W-1:0]    ca_rise, ca_fall;
  logic [lbt_pkg::DQ_W-1:0]    wdq_rise, wdq_fall, rd_word_rise, rd_word_fall, rdq_rise, rdq_fall, last_rd;
  logic [lbt_pkg::DM_W-1:0]    wdm_rise, wdm_fall;
  logic [lbt_pkg::WORD_W-1:0]  wb_data;
  logic [lbt_pkg::BE_W-1:0]    wb_byte_en;
  logic [lbt_pkg::COL_W-1:0]   wb_col, rd_fetch_col;
  logic [lbt_pkg::BANK_W-1:0]  wb_bank, rd_fetch_bank;
  logic [4:0]                  rd_eff_len, wr_eff_len;
  logic [1:0]                  kind;
  logic [3:0]                  clks;
  int                          bad_count = 0, n_checks = 0, words = 0, fetches = 0;

  always #4 ref_clk = ~ref_clk;
  assign rd_word_rise = {5'h15, rd_fetch_col};
  assign rd_word_fall = ~{5'h15, rd_fetch_col};

  lbt_host_model i_host (.ref_clk(ref_clk), .read_lat(read_lat), .write_lat(write_lat), .cs_n(cs_n),
    .ca_rise(ca_rise), .ca_fall(ca_fall), .wdq_rise(wdq_rise), .wdq_fall(wdq_fall),
    .wdm_rise(wdm_rise), .wdm_fall(wdm_fall));
  lbt_burst_engine i_dut (.ref_clk(ref_clk), .reset(reset), .burst_len_sel(burst_len_sel),
    .read_lat(read_lat), .write_lat(write_lat), .cs_n(cs_n), .ca_rise(ca_rise), .ca_fall(ca_fall),
    .wdq_rise(wdq_rise), .wdq_fall(wdq_fall), .wdm_rise(wdm_rise), .wdm_fall(wdm_fall),
    .wb_valid(wb_valid), .wb_ready(wb_ready), .wb_data(wb_data), .wb_byte_en(wb_byte_en),
    .wb_col(wb_col), .wb_bank(wb_bank), .wr_overrun(wr_overrun), .rd_fetch(rd_fetch),
    .rd_fetch_col(rd_fetch_col), .rd_fetch_bank(rd_fetch_bank), .rd_word_rise(rd_word_rise),
    .rd_word_fall(rd_word_fall), .rdq_rise(rdq_rise), .rdq_fall(rdq_fall), .rdq_oe(rdq_oe),
    .rdqs_oe(rdqs_oe), .rd_eff_len(rd_eff_len), .wr_eff_len(wr_eff_len));

  task automatic check_eq(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // sampled at the falling edge, where every output has settled after the rising edge
  always @(negedge ref_clk) begin
    if (reset === 1'b0) begin
      if (rdq_oe === 1'b1) check_eq(64'({rdq_fall, rdq_rise}), 64'({~last_rd, last_rd}));
      check_eq(64'(rdqs_oe), 64'(rd_fetch | rdq_oe));
      if (rd_fetch === 1'b1) begin
        fetches++;
        if (i_host.rd_q.size() == 0) check_eq(64'h1, 64'h0);
        else check_eq(64'({rd_fetch_bank, rd_fetch_col}), 64'(i_host.rd_q.pop_front()));
        last_rd = rd_word_rise;
      end
      if (wb_valid === 1'b1 && wb_ready === 1'b1) begin
        words++;
        if (i_host.exp_q.size() == 0) check_eq(64'h1, 64'h0);
        else check_eq(64'({wb_bank, wb_col, wb_byte_en, wb_data}), 64'(i_host.exp_q.pop_front()));
      end
    end
  end

  initial begin
    repeat (6000) @(posedge ref_clk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      @(posedge ref_clk);
      burst_len_sel <= rows[i].bl;
      read_lat      <= rows[i].lat;
      write_lat     <= rows[i].lat;
      repeat (4) @(posedge ref_clk);
      words   = 0;
      fetches = 0;
      kind    = {1'b0, rows[i].rd};
      clks    = 4'h2 << rows[i].bl;
      i_host.issue(kind, 11'(i) << 4, 2'(i), clks);
      if (rows[i].nxt != 2'h0) begin
        repeat (rows[i].gap - 2) @(posedge ref_clk);
        i_host.issue((rows[i].nxt == 2'h2) ? 2'h2 : kind, 11'h200, 2'(i + 1), clks);
      end
      // long idle tail keeps every read/write turnaround satisfied
      repeat (60) @(posedge ref_clk);
      check_eq(64'(rows[i].rd ? fetches : words), 64'(rows[i].n_clk));
      check_eq(64'(rows[i].rd ? rd_eff_len : wr_eff_len), 64'(rows[i].eff));
      check_eq(64'(wr_overrun), 64'h0);
      $display("row %0d done", i);
    end
    // receiver stalls through a BL16 write: two words kept, the rest dropped
    wb_ready      <= 1'b0;
    burst_len_sel <= 2'h2;
    write_lat     <= 4'h1;
    repeat (4) @(posedge ref_clk);
    words = 0;
    i_host.issue(2'h0, 11'h300, 2'h3, 4'h8);
    repeat (30) @(posedge ref_clk);
    check_eq(64'({wr_overrun, wb_valid}), 64'h3);
    wb_ready <= 1'b1;
    repeat (6) @(posedge ref_clk);
    check_eq(64'(words), 64'h2);
    check_eq(64'({wr_overrun, wb_valid}), 64'h2);
    i_host.exp_q.delete();
    $display("stall test done");
    // a second terminate with no new command in between must leave the length alone
    fetches = 0;
    i_host.issue(2'h1, 11'h100, 2'h1, 4'h8);
    i_host.issue(2'h2, 11'h000, 2'h0, 4'h8);
    i_host.issue(2'h2, 11'h000, 2'h0, 4'h8);
    repeat (30) @(posedge ref_clk);
    check_eq(64'({rd_eff_len, 5'(fetches)}), 64'h082);
    $display("double terminate test done");
    // a second reset mid-run clears the sticky flag and the lengths
    reset <= 1'b1;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(negedge ref_clk);
    check_eq(64'({wr_overrun, wb_valid, rd_eff_len, wr_eff_len}), 64'h0);
    $display("reset test done");
    report_and_stop();
  end
endmodule
